// ===== hw/rpk_pkg.sv
package rpk_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and pulse timing, in nanoseconds
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned T0H_NS           = 300;
  localparam int unsigned T1H_NS           = 900;
  localparam int unsigned T_SAMPLE_NS      = 600;
  localparam int unsigned T_QUERY_HIGH_NS  = 2000;
  localparam int unsigned T_QUERY_SPLIT_NS = 1450;
  localparam int unsigned T_RESET_LOW_NS   = 250000;
  localparam int unsigned T_WAKE_NS        = 1000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counts derived from the times above
  localparam int unsigned CNT_W      = 9;
  localparam int unsigned LONG_W     = 20;
  localparam logic [8:0]  CNT_MAX    = 9'h1FF;
  // Bit decision point, midway between the two high widths
  localparam logic [8:0]  SAMPLE_CYC = 9'((T_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Regenerated high widths, rounded to the nearest cycle
  localparam logic [8:0]  T0H_CYC    = 9'((T0H_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
  localparam logic [8:0]  T1H_CYC    = 9'((T1H_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
  localparam logic [8:0]  QH_CYC     = 9'(T_QUERY_HIGH_NS / CLK_PERIOD_NS);
  // High pulses at or above this width are query codes
  localparam logic [8:0]  QSPLIT_CYC = 9'((T_QUERY_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Least reset-low time rounds up, longest wake time rounds down
  localparam int unsigned RESET_CYC_DEF = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC_DEF  = T_WAKE_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Word layout and reset values
  localparam logic [4:0]  WORD_LAST          = 5'h17;
  localparam logic [3:0]  TAIL_FULL          = 4'h8;
  localparam logic [7:0]  SLEEP_COMMAND_BYTE = 8'h5A;
  localparam int unsigned CHAN_W             = 8;
  localparam int unsigned NUM_CHAN           = 3;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rpk_colour_t;

  localparam rpk_colour_t COLOUR_RST = 24'h000000;

  // Power states, Gray coded along active -> sleep -> wake
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_SLEEP  = 2'b01,
    PWR_WAKE   = 2'b11
  } rpk_pwr_t;

endpackage

// ===== hw/rpk_pwm.sv
`timescale 1ns/1ps
module rpk_pwm
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_run,
  input  wire logic [7:0] i_duty,
  output logic            o_pwm
);

  logic [7:0] phase;

  ////////////////////////////////////////////////////////////////////////////////
  // Free 256-step phase; stopped and dark while the oscillator is off
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !i_run)
    begin
      phase <= 8'h00;
      o_pwm <= 1'b0;
    end
    else
    begin
      phase <= phase + 8'h01;
      o_pwm <= (phase < i_duty); // Duty 0 stays dark, 255 is on 255 of 256 steps
    end
  end

  default clocking pwm_cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  duty_zero_dark_a: assert property (i_run && i_duty == 8'h00 |=> !o_pwm)
    else $error("channel lit with zero duty");
  duty_full_lit_a: assert property (i_run && $past(i_run) && $past(i_duty) == 8'hFF
                                    && $past(phase) != 8'hFF |-> o_pwm)
    else $error("channel dark with full duty");
  pwm_lit_c: cover property (i_run && o_pwm ##1 !o_pwm);

endmodule // rpk_pwm

// ===== hw/rpk_top.sv
`timescale 1ns/1ps
module rpk_top
#(
  parameter int unsigned RESET_CYC = rpk_pkg::RESET_CYC_DEF,
  parameter int unsigned WAKE_CYC  = rpk_pkg::WAKE_CYC_DEF
)
(
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_serial_in_primary,
  input  wire logic          i_serial_in_bypass,
  input  wire logic          i_upstream_failed,
  output logic               o_serial_out,
  output logic               o_key_out,
  output logic               o_key_oe,
  output logic [2:0]         o_pwm_rgb,
  output rpk_pkg::rpk_colour_t o_colour,
  output logic               o_osc_run,
  output logic               o_asleep
);

  localparam logic [19:0] RESET_LIM = 20'(RESET_CYC);
  localparam logic [19:0] WAKE_LIM  = 20'(WAKE_CYC);

  logic               sel_in;
  logic               in_q;
  logic               prim_q;
  logic               byp_q;
  logic               rise;
  logic               fall;
  logic               wake_edge;
  logic               run;
  logic [8:0]         hi_cnt;
  logic [19:0]        lo_cnt;
  logic               reset_cmd;
  logic               is_query;
  logic               bit_val;
  logic               own_pulse;
  logic               fwd_cur;
  logic [4:0]         bit_cnt;
  logic               own_done;
  logic [23:0]        shift;
  logic [23:0]        next_word;
  logic               word_zero;
  logic [7:0]         tail;
  logic [3:0]         tail_n;
  logic               key_low;
  logic               sleep_go;
  rpk_pkg::rpk_pwr_t  pwr;
  logic [19:0]        wake_cnt;
  logic               samp_on;
  logic [8:0]         samp_cnt;
  logic               watch;
  logic               start_emit;
  logic               emit_on;
  logic               emit_long;
  logic               emit_q;
  logic [8:0]         emit_cnt;
  logic               emit_end;

  ////////////////////////////////////////////////////////////////////////////////
  // Input choice and edges; these flops stay on through sleep to catch the wake edge
  assign sel_in = i_upstream_failed ? i_serial_in_bypass : i_serial_in_primary;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      in_q   <= 1'b0;
      prim_q <= 1'b0;
      byp_q  <= 1'b0;
    end
    else
    begin
      in_q   <= sel_in;
      prim_q <= i_serial_in_primary;
      byp_q  <= i_serial_in_bypass;
    end
  end

  assign rise      = run && sel_in && !in_q;
  assign fall      = run && !sel_in && in_q;
  assign wake_edge = (i_serial_in_primary && !prim_q) || (i_serial_in_bypass && !byp_q);
  assign run       = (pwr == rpk_pkg::PWR_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse width counters
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !run || rise)
      hi_cnt <= 9'h000;
    else if (sel_in && hi_cnt != rpk_pkg::CNT_MAX)
      hi_cnt <= hi_cnt + 9'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !run || sel_in)
      lo_cnt <= 20'h00000;
    else if (lo_cnt != RESET_LIM)
      lo_cnt <= lo_cnt + 20'h00001;
  end

  // Fires once per long low; hi width decides 0, 1 or query at the falling edge
  assign reset_cmd = run && !sel_in && (lo_cnt == RESET_LIM - 20'h00001);
  assign is_query  = (hi_cnt >= rpk_pkg::QSPLIT_CYC);
  assign bit_val   = (hi_cnt >= rpk_pkg::SAMPLE_CYC);
  assign own_pulse = fall && !fwd_cur;
  assign next_word = {shift[22:0], bit_val};

  ////////////////////////////////////////////////////////////////////////////////
  // Own-slot reception: colour word or query code
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      fwd_cur   <= 1'b0;
      bit_cnt   <= 5'h00;
      own_done  <= 1'b0;
      shift     <= 24'h000000;
      o_colour  <= rpk_pkg::COLOUR_RST;
      word_zero <= 1'b0;
    end
    else if (reset_cmd)
    begin
      bit_cnt   <= 5'h00;
      own_done  <= 1'b0;
      word_zero <= 1'b0;
    end
    else
    begin
      if (rise)
        fwd_cur <= own_done;
      if (own_pulse && is_query && bit_cnt == 5'h00)
        own_done <= 1'b1; // Slot used, colour untouched
      else if (own_pulse && !is_query)
      begin
        shift   <= next_word; // MSB first
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == rpk_pkg::WORD_LAST)
        begin
          o_colour  <= next_word;
          own_done  <= 1'b1;
          word_zero <= (next_word == 24'h000000);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Last eight forwarded data bits, watched for the sleep byte
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || reset_cmd)
    begin
      tail   <= 8'h00;
      tail_n <= 4'h0;
    end
    else if (fall && fwd_cur && is_query)
      tail_n <= 4'h0; // A query breaks any byte in progress
    else if (fall && fwd_cur)
    begin
      tail <= {tail[6:0], bit_val};
      if (tail_n != rpk_pkg::TAIL_FULL)
        tail_n <= tail_n + 4'h1;
    end
  end

  assign sleep_go = reset_cmd && word_zero && tail_n == rpk_pkg::TAIL_FULL
                    && tail == rpk_pkg::SLEEP_COMMAND_BYTE;

  ////////////////////////////////////////////////////////////////////////////////
  // Key pull: set after the first own pulse, dropped at the first rising edge once the own slot is done
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || reset_cmd || !run)
      key_low <= 1'b0;
    else if (own_pulse && bit_cnt == 5'h00 && !own_done)
      key_low <= 1'b1;
    else if (rise && own_done)
      key_low <= 1'b0;
  end

  assign o_key_out = 1'b0;
  assign o_key_oe  = key_low || (pwr == rpk_pkg::PWR_SLEEP);

  ////////////////////////////////////////////////////////////////////////////////
  // Power state; the wake wait is a full 1 ms so downstream circuits are settled
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      pwr      <= rpk_pkg::PWR_ACTIVE;
      wake_cnt <= 20'h00000;
    end
    else
    begin
      case (pwr)
        rpk_pkg::PWR_ACTIVE:
          if (sleep_go)
            pwr <= rpk_pkg::PWR_SLEEP;
        rpk_pkg::PWR_SLEEP:
          if (wake_edge)
          begin
            pwr      <= rpk_pkg::PWR_WAKE;
            wake_cnt <= 20'h00000;
          end
        rpk_pkg::PWR_WAKE:
          if (wake_cnt == WAKE_LIM - 20'h00001)
            pwr <= rpk_pkg::PWR_ACTIVE;
          else
            wake_cnt <= wake_cnt + 20'h00001;
        default:
          pwr <= rpk_pkg::PWR_ACTIVE;
      endcase
    end
  end

  assign o_osc_run = (pwr != rpk_pkg::PWR_SLEEP);
  assign o_asleep  = (pwr == rpk_pkg::PWR_SLEEP);

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarding: sample at midpoint, then emit a nominal pulse. Adds one sample
  // time of latency per pixel, traded for clean widths down the chain.
  assign start_emit = samp_on && (samp_cnt == rpk_pkg::SAMPLE_CYC - 9'h001);
  assign emit_end   = (!emit_long && emit_cnt == rpk_pkg::T0H_CYC - 9'h001)
                   || (emit_long && !emit_q && emit_cnt == rpk_pkg::T1H_CYC - 9'h001)
                   || (emit_cnt == rpk_pkg::QH_CYC - 9'h001);

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      samp_on      <= 1'b0;
      samp_cnt     <= 9'h000;
      watch        <= 1'b0;
      emit_on      <= 1'b0;
      emit_long    <= 1'b0;
      emit_q       <= 1'b0;
      emit_cnt     <= 9'h000;
      o_serial_out <= 1'b0;
    end
    else if (!run)
    begin
      samp_on      <= 1'b0;
      watch        <= 1'b0;
      emit_on      <= 1'b0;
      o_serial_out <= i_serial_in_primary; // Wake pulse on the primary line passes straight on
    end
    else
    begin
      if (rise && own_done)
      begin
        samp_on  <= 1'b1;
        samp_cnt <= 9'h000;
        watch    <= 1'b1;
      end
      else if (start_emit)
        samp_on <= 1'b0;
      else if (samp_on)
        samp_cnt <= samp_cnt + 9'h001;
      // Watch whether the forwarded pulse lasts long enough to be a query
      if (watch && fall)
        watch <= 1'b0;
      else if (watch && sel_in && hi_cnt == rpk_pkg::QSPLIT_CYC - 9'h001)
        watch <= 1'b0;
      if (start_emit)
      begin
        emit_on      <= 1'b1;
        emit_long    <= sel_in;
        emit_q       <= 1'b0;
        emit_cnt     <= 9'h000;
        o_serial_out <= 1'b1;
      end
      else if (emit_on)
      begin
        if (watch && sel_in && hi_cnt == rpk_pkg::QSPLIT_CYC - 9'h001)
          emit_q <= 1'b1;
        if (emit_end)
        begin
          emit_on      <= 1'b0;
          o_serial_out <= 1'b0;
        end
        else
          emit_cnt <= emit_cnt + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Three PWM channels, one per colour byte
  for (genvar ch = 0; ch < rpk_pkg::NUM_CHAN; ch++)
  begin : g_chan
    rpk_pwm u_pwm
    (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_run  (run),
      .i_duty (o_colour[ch*rpk_pkg::CHAN_W +: rpk_pkg::CHAN_W]),
      .o_pwm  (o_pwm_rgb[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking top_cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  fwd_after_own_a: assert property (start_emit |-> own_done)
    else $error("bit forwarded before own word complete");
  colour_load_a: assert property (own_pulse && !is_query && bit_cnt == rpk_pkg::WORD_LAST
                                  && !reset_cmd |=> o_colour == $past(next_word))
    else $error("colour word not loaded on 24th bit");
  zero_decode_a: assert property (own_pulse && !reset_cmd && hi_cnt < rpk_pkg::SAMPLE_CYC
                                  |=> shift[0] == 1'b0)
    else $error("short pulse not decoded as zero");
  one_decode_a: assert property (own_pulse && !reset_cmd && bit_val && !is_query
                                 |=> shift[0] == 1'b1)
    else $error("long pulse not decoded as one");
  reset_restart_a: assert property (reset_cmd |=> bit_cnt == 5'h00 && !own_done && !key_low)
    else $error("reset command did not restart");
  key_fall_a: assert property (own_pulse && !reset_cmd && bit_cnt == 5'h00 && !own_done
                               |=> o_key_oe ##1 (o_key_oe || !run))
    else $error("key not pulled after first own pulse");
  key_release_a: assert property (rise && own_done && key_low && !reset_cmd
                                  |=> !key_low)
    else $error("key not released on next rising edge");
  query_keep_a: assert property (own_pulse && is_query && bit_cnt == 5'h00 && !own_done
                                 && !reset_cmd |=> $stable(o_colour) && key_low && own_done)
    else $error("own query mishandled");
  sleep_key_a: assert property (sleep_go |=> o_asleep && o_key_oe && !o_osc_run)
    else $error("sleep entry did not pull key or stop oscillator");
  wake_bound_a: assert property (!run && !o_asleep
                                 && wake_cnt == WAKE_LIM - 20'h00001 |=> run)
    else $error("device not back to normal after wake wait");
  wake_pass_a: assert property (!run ##1 !run |-> o_serial_out == $past(i_serial_in_primary))
    else $error("wake pulse not passed downstream");
  sleep_wake_a: assert property (pwr == rpk_pkg::PWR_SLEEP && wake_edge
                                 |=> pwr == rpk_pkg::PWR_WAKE)
    else $error("edge did not wake device");

  sleep_entry_c: cover property (sleep_go ##1 pwr == rpk_pkg::PWR_SLEEP);
  own_query_c:   cover property (own_pulse && is_query && bit_cnt == 5'h00);
  word_done_c:   cover property (own_pulse && bit_cnt == rpk_pkg::WORD_LAST ##[1:400] start_emit);
  wake_done_c:   cover property (pwr == rpk_pkg::PWR_WAKE ##1 pwr == rpk_pkg::PWR_ACTIVE);

endmodule // rpk_top

// ===== verif/rpk_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Upstream host driving one serial line, plus the key net
module rpk_host_model
#(
  parameter int unsigned RST_CYC = 400,
  parameter int unsigned WK_CYC  = 200
)
(
  input  wire logic i_clk,
  input  wire logic i_key_oe,
  output logic      o_line,
  output logic      o_key_line
);
  // Weak pull-up on the shared key net, a pulled pin wins
  assign o_key_line = i_key_oe ? 1'b0 : 1'b1;
  initial o_line = 1'b0;

  ////////////////////////////////////////////////////////////
  // One high/low pulse, edges launched on the rising edge
  task automatic pulse(input int hi, input int lo);
    @(posedge i_clk);
    o_line <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_line <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask

  // Bit period kept near 1.2 us, the pulse task adds one low cycle
  task automatic send_bit(input logic b);
    if (b)
      pulse(113, 36);
    else
      pulse(38, 111);
  endtask

  // Lowest n bits of v, most significant first
  task automatic send_bits(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      send_bit(v[i]);
  endtask

  task automatic query;
    pulse(250, 249);
  endtask

  // Margin past the threshold so the command always fires
  task automatic send_reset;
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (RST_CYC + 8) @(posedge i_clk);
  endtask

  // Short positive pulse, then hold off until the chain is awake
  task automatic wake;
    pulse(10, 10);
    repeat (WK_CYC + 8) @(posedge i_clk);
  endtask
endmodule // rpk_host_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int unsigned RC = 400;
  localparam int unsigned WC = 200;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 failed = 1'b0;
  logic                 prim_line;
  logic                 byp_line;
  logic                 key_line;
  logic                 o_serial_out;
  logic                 o_key_out;
  logic                 o_key_oe;
  logic [2:0]           o_pwm_rgb;
  rpk_pkg::rpk_colour_t o_colour;
  logic                 o_osc_run;
  logic                 o_asleep;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  int                   hi_run = 0;
  int                   widths[$];

  always #4 clk = ~clk;

  rpk_top #(.RESET_CYC(RC), .WAKE_CYC(WC)) i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_serial_in_primary(prim_line),
    .i_serial_in_bypass(byp_line), .i_upstream_failed(failed),
    .o_serial_out(o_serial_out), .o_key_out(o_key_out), .o_key_oe(o_key_oe),
    .o_pwm_rgb(o_pwm_rgb), .o_colour(o_colour), .o_osc_run(o_osc_run),
    .o_asleep(o_asleep));
  rpk_host_model #(.RST_CYC(RC), .WK_CYC(WC)) prim (
    .i_clk(clk), .i_key_oe(o_key_oe), .o_line(prim_line), .o_key_line(key_line));
  rpk_host_model #(.RST_CYC(RC), .WK_CYC(WC)) byp (
    .i_clk(clk), .i_key_oe(o_key_oe), .o_line(byp_line), .o_key_line());

  ////////////////////////////////////////////////////////////
  // Downstream watcher: width of every high pulse on the output
  always @(posedge clk)
  begin
    if (o_serial_out === 1'b1)
      hi_run++;
    else if (hi_run != 0)
    begin
      widths.push_back(hi_run);
      hi_run = 0;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    @(negedge clk);
    check("colour", 32'(o_colour), 32'h0);
    check("key oe", 32'(o_key_oe), 32'h0);
    check("key pin", 32'(o_key_out), 32'h0);
    check("osc", 32'(o_osc_run), 32'h1);
    check("asleep", 32'(o_asleep), 32'h0);
    $display("test reset values done");
  endtask

  // Own word, then a forwarded word; key window and pwm duty
  task automatic t_word;
    int cnt[3];
    int d;
    cnt = '{0, 0, 0};
    prim.send_reset();
    widths.delete();
    @(negedge clk);
    check("key before", 32'(o_key_oe), 32'h0);
    prim.send_bits(24'h000001, 1);
    @(negedge clk);
    check("key after first", 32'(o_key_oe), 32'h1);
    check("key net", 32'(key_line), 32'h0);
    prim.send_bits(24'h25C33C, 23);
    repeat (3) @(negedge clk);
    check("colour", 32'(o_colour), 32'hA5C33C);
    check("own not forwarded", 32'(widths.size()), 32'h0);
    // Sample across one full 256-level period
    repeat (256)
    begin
      @(negedge clk);
      for (int k = 0; k < 3; k++)
        cnt[k] += int'(o_pwm_rgb[2 - k]);
    end
    for (int k = 0; k < 3; k++)
    begin
      d = cnt[k] - int'(8'(24'hA5C33C >> (16 - 8 * k)));
      check("pwm duty", 32'(d >= -1 && d <= 1), 32'h1);
    end
    prim.send_bits(24'h000001, 1);
    @(negedge clk);
    check("key release", 32'(o_key_oe), 32'h0);
    prim.send_bits(24'h000001, 23);
    repeat (60) @(negedge clk);
    check("colour kept", 32'(o_colour), 32'hA5C33C);
    check("forward count", 32'(widths.size()), 32'd24);
    foreach (widths[i])
      check("fwd width", widths[i], (i == 0 || i == 23) ? 32'd113 : 32'd38);
    $display("test colour word done");
  endtask

  task automatic t_query;
    prim.send_reset();
    widths.delete();
    prim.query();
    @(negedge clk);
    check("query key", 32'(o_key_oe), 32'h1);
    check("query colour", 32'(o_colour), 32'hA5C33C);
    prim.query();
    @(negedge clk);
    check("query release", 32'(o_key_oe), 32'h0);
    check("query fwd", widths.size() == 1 ? widths[0] : 0, 32'd250);
    $display("test query done");
  endtask

  // Zero own word, sleep byte, reset command, on either line
  task automatic go_sleep(input logic use_byp);
    if (use_byp)
    begin
      byp.send_reset();
      byp.send_bits(24'h0, 24);
      byp.send_bits(24'h5A, 8);
      byp.send_reset();
    end
    else
    begin
      prim.send_reset();
      prim.send_bits(24'h0, 24);
      prim.send_bits(24'h5A, 8);
      prim.send_reset();
    end
    @(negedge clk);
    check("asleep", 32'(o_asleep), 32'h1);
    check("osc stop", 32'(o_osc_run), 32'h0);
    check("sleep key", 32'(o_key_oe), 32'h1);
    check("sleep pwm", 32'(o_pwm_rgb), 32'h0);
  endtask

  task automatic t_sleep;
    go_sleep(1'b0);
    byp.pulse(10, 10);
    @(negedge clk);
    check("bypass wake", 32'(o_asleep), 32'h0);
    check("osc back", 32'(o_osc_run), 32'h1);
    repeat (WC + 8) @(posedge clk);
    prim.send_reset();
    prim.send_bits(24'h123456, 24);
    repeat (3) @(negedge clk);
    check("after wake", 32'(o_colour), 32'h123456);
    prim.send_bits(24'h5A, 8);
    prim.send_reset();
    @(negedge clk);
    check("nonzero stays", 32'(o_asleep), 32'h0);
    go_sleep(1'b0);
    widths.delete();
    prim.wake();
    @(negedge clk);
    check("primary wake", 32'(o_asleep), 32'h0);
    check("wake passed", widths.size() == 1 ? widths[0] : 0, 32'd10);
    $display("test sleep done");
  endtask

  // Failed upstream: decode, sleep and wake all from the bypass line
  task automatic t_bypass;
    @(posedge clk);
    failed <= 1'b1;
    byp.send_reset();
    byp.send_bits(24'h0F1E2D, 24);
    repeat (3) @(negedge clk);
    check("bypass colour", 32'(o_colour), 32'h0F1E2D);
    go_sleep(1'b1);
    byp.wake();
    @(negedge clk);
    check("bypass wake", 32'(o_asleep), 32'h0);
    $display("test bypass done");
  endtask

  ////////////////////////////////////////////////////////////
  // Watchdog: a run that overstays its bound is a failure
  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset_vals();
    t_word();
    t_query();
    t_sleep();
    t_bypass();
    end_sim();
  end
endmodule // testbench
